// ### design/ethernet_mac_config_stats.v
// MAC configuration, gap, station address and FCS error statistics
//
// Function
// - Count good-length frames with bad FCS
// - Clear counter on read at +0 unless low bytes disabled
// - Soft reset bit holds whole MAC, resets one
// - Simulation reset restarts transmit random generator
// - Four bits hold rx/tx sublayers in reset
// - Loopback routes transmit back into receive
// - Allow or block sending pause frames
// - Act on or ignore received pause frames
// - Pass all frames or drop control frames
// - Receive frames only when enabled
// - 16/32-bit reads and low-half/32-bit writes taken, upper-half writes and 8-bit ignored
// - Seven-bit gap field in nibble times
// - Gap field offset three full, six half
// - Station octet one low, two high
// - Station address loads factory value in the first cycle after reset release
// - Clear, set, invert aliases at +4/8/C
`timescale 1ns/1ps
`include "mac_cfg_defs.vh"

module ethernet_mac_config_stats #(
    parameter [15:0] FACTORY_STATION = `FACTORY_STATION_LOW,
    parameter        NIBBLE_DIV      = 10
) (
    input  wire        mclk,
    input  wire        rst_b,
    input  wire        busRead,
    input  wire        busWrite,
    input  wire [11:0] busAddr,
    input  wire [3:0]  busByteEn,
    input  wire [31:0] busWriteData,
    output reg  [31:0] busReadData,
    output reg         busReady,
    input  wire        rxFrameDone,
    input  wire        rxFcsBad,
    input  wire [2:0]  rxBitLenLow,
    input  wire        rxIsControl,
    input  wire        rxIsPause,
    input  wire        rxFromPhy,
    input  wire        txFrameValid,
    input  wire        txIsPause,
    input  wire        txFrameEnd,
    input  wire        fullDuplex,
    output reg         rxAccept,
    output reg         pauseHonored,
    output reg         txPausePermit,
    output reg         rxSourceLoop,
    output reg         txGapOpen,
    output reg         macLogicHold,
    output reg         rxControlHold,
    output reg         rxFunctionHold,
    output reg         txControlHold,
    output reg         txFunctionHold,
    output reg  [9:0]  backoffValue,
    output reg  [47:0] stationAddrLow
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg  [15:0] badCheckFrameTally;
    reg  [15:0] macConfigOne;
    reg  [6:0]  packetGapNibbles;
    reg  [7:0]  stationOctetFirst;
    reg  [7:0]  stationOctetSecond;
    reg         factoryLoad;
    reg  [3:0]  nibbleCount;
    reg         nibbleTick;

    wire [9:0]  lfsrValue;
    wire        gapOpenRaw;

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    wire [11:0] baseAddr  = {busAddr[11:4], 4'h0};
    wire [1:0]  aliasSel  = busAddr[3:2];
    // Only halfword pairs or the full word count as a legal width
    wire lowHalf   = (busByteEn == 4'h3);
    wire highHalf  = (busByteEn == 4'hc);
    wire fullWord  = (busByteEn == 4'hf);
    wire wideOk    = lowHalf || highHalf || fullWord;
    wire lowLanes  = lowHalf || fullWord;

    wire selFcs    = (baseAddr == `OFS_FCS_ERROR_COUNT);
    wire selCfg    = (baseAddr == `OFS_MAC_CONFIG_ONE);
    wire selGap    = (baseAddr == `OFS_BACK_TO_BACK_GAP);
    wire selSta    = (baseAddr == `OFS_STATION_ADDR_LOW);

    wire wrTake    = busWrite && wideOk && lowLanes;
    wire rdTake    = busRead && wideOk;

    // Apply alias operation to a 16-bit value
    function [15:0] aliasApply;
        input [15:0] oldValue;
        input [15:0] data;
        input [1:0]  sel;
        begin
            case (sel)
                `OFS_ALIAS_CLEAR:  aliasApply = oldValue & ~data;
                `OFS_ALIAS_SET:    aliasApply = oldValue | data;
                `OFS_ALIAS_INVERT: aliasApply = oldValue ^ data;
                default:           aliasApply = data;
            endcase
        end
    endfunction

    // Frame with bad FCS and whole-octet length
    wire fcsEvent = rxFrameDone && rxFcsBad && (rxBitLenLow == 3'h0) &&
                    !macLogicHold && !rxFunctionHold;
    wire fcsClearRead = rdTake && selFcs && aliasSel == 2'h0 &&
                        (busByteEn[1:0] != 2'h0);
    wire [15:0] gapAliased = aliasApply({9'h000, packetGapNibbles},
                                        busWriteData[15:0], aliasSel);

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_b) begin
            badCheckFrameTally <= 16'h0000;
            macConfigOne       <= `RST_MAC_CONFIG_ONE;
            packetGapNibbles   <= `RST_BACK_TO_BACK_GAP;
            factoryLoad        <= 1'b1;
            stationOctetFirst  <= 8'h00;
            stationOctetSecond <= 8'h00;
        end else begin
            factoryLoad <= 1'b0;
            // Factory value captured after release, not under reset
            if (factoryLoad) begin
                stationOctetFirst  <= FACTORY_STATION[7:0];
                stationOctetSecond <= FACTORY_STATION[15:8];
            end else if (wrTake && selSta) begin
                {stationOctetSecond, stationOctetFirst} <=
                    aliasApply({stationOctetSecond, stationOctetFirst},
                               busWriteData[15:0], aliasSel);
            end
            if (wrTake && selCfg) begin
                macConfigOne <= aliasApply(macConfigOne, busWriteData[15:0],
                                           aliasSel) & `MASK_MAC_CONFIG_ONE;
            end
            if (wrTake && selGap) begin
                packetGapNibbles <= gapAliased[6:0];
            end
            // Clearing read keeps a same-cycle increment as one; a bus write wins over both
            if (wrTake && selFcs) begin
                badCheckFrameTally <= aliasApply(badCheckFrameTally,
                                                 busWriteData[15:0], aliasSel);
            end else if (fcsClearRead) begin
                badCheckFrameTally <= fcsEvent ? 16'h0001 : 16'h0000;
            end else if (fcsEvent) begin
                badCheckFrameTally <= badCheckFrameTally + 16'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Bus read
    // ---------------------------------------------------------------
    reg [15:0] next_readValue;
    always @* begin
        next_readValue = 16'h0000;
        if (selFcs) begin
            next_readValue = badCheckFrameTally;
        end else if (selCfg) begin
            next_readValue = macConfigOne;
        end else if (selGap) begin
            next_readValue = {9'h000, packetGapNibbles};
        end else if (selSta) begin
            next_readValue = {stationOctetSecond, stationOctetFirst};
        end
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            busReadData <= 32'h00000000;
            busReady    <= 1'b0;
        end else begin
            // Unmapped and 8-bit accesses still complete, reading zero
            busReady    <= busRead || busWrite;
            busReadData <= rdTake ? {16'h0000, next_readValue} : 32'h00000000;
        end
    end

    // ---------------------------------------------------------------
    // Nibble-time enable
    // ---------------------------------------------------------------
    always @(posedge mclk) begin
        if (!rst_b || nibbleCount == NIBBLE_DIV[3:0] - 4'h1) begin
            nibbleCount <= 4'h0;
            nibbleTick  <= rst_b;
        end else begin
            nibbleCount <= nibbleCount + 4'h1;
            nibbleTick  <= 1'b0;
        end
    end

    gap_timer u_gap (
        .mclk             (mclk),
        .rst_b            (rst_b),
        .hold             (macLogicHold || txFunctionHold),
        .nibbleTick       (nibbleTick),
        .fullDuplex       (fullDuplex),
        .packetGapNibbles (packetGapNibbles),
        .txFrameEnd       (txFrameEnd),
        .gapOpen          (gapOpenRaw)
    );

    backoff_lfsr #(.WIDTH(10)) u_lfsr (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .restart (macConfigOne[`BIT_BACKOFF_RESTART] || macLogicHold),
        .value   (lfsrValue)
    );

    // ---------------------------------------------------------------
    // Control outputs
    // ---------------------------------------------------------------
    wire holdAll = macConfigOne[`BIT_WHOLE_MAC_HOLD];
    wire rxOn    = macConfigOne[`BIT_RECEIVE_ON];
    wire rxBlock = holdAll || macConfigOne[`BIT_RX_FUNC_HOLD] ||
                   macConfigOne[`BIT_RX_CTRL_HOLD];
    wire rxFrom  = macConfigOne[`BIT_LOOPBACK] ? txFrameValid : rxFromPhy;
    wire ctlPass = !rxIsControl || macConfigOne[`BIT_ACCEPT_EVERY];

    always @(posedge mclk) begin
        if (!rst_b) begin
            // Soft reset bit resets set, so every sub-block hold starts set too
            macLogicHold   <= 1'b1;
            rxControlHold  <= 1'b1;
            rxFunctionHold <= 1'b1;
            txControlHold  <= 1'b1;
            txFunctionHold <= 1'b1;
            rxAccept       <= 1'b0;
            pauseHonored   <= 1'b0;
            txPausePermit  <= 1'b0;
            rxSourceLoop   <= 1'b0;
            txGapOpen      <= 1'b0;
            backoffValue   <= 10'h000;
            stationAddrLow <= 48'h000000000000;
        end else begin
            macLogicHold   <= holdAll;
            rxControlHold  <= holdAll || macConfigOne[`BIT_RX_CTRL_HOLD];
            rxFunctionHold <= holdAll || macConfigOne[`BIT_RX_FUNC_HOLD];
            txControlHold  <= holdAll || macConfigOne[`BIT_TX_CTRL_HOLD];
            txFunctionHold <= holdAll || macConfigOne[`BIT_TX_FUNC_HOLD];
            rxSourceLoop   <= macConfigOne[`BIT_LOOPBACK];
            rxAccept       <= rxFrom && rxOn && !rxBlock && ctlPass;
            pauseHonored   <= rxFrom && rxIsPause && rxOn && !rxBlock &&
                              macConfigOne[`BIT_HONOR_FLOW_STOP];
            txPausePermit  <= txFrameValid && txIsPause && !holdAll &&
                              !macConfigOne[`BIT_TX_CTRL_HOLD] &&
                              macConfigOne[`BIT_SEND_FLOW_STOP];
            txGapOpen      <= gapOpenRaw && !holdAll;
            backoffValue   <= lfsrValue;
            // Upper four octets live in other registers, kept zero here
            stationAddrLow <= {32'h00000000, stationOctetSecond,
                               stationOctetFirst};
        end
    end
endmodule // ethernet_mac_config_stats

// ### design/mac_cfg_defs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef MAC_CFG_DEFS_VH
`define MAC_CFG_DEFS_VH

// ---------------------------------------------------------------
// Register byte offsets (aligned words)
// ---------------------------------------------------------------
`define OFS_FCS_ERROR_COUNT    12'h150
`define OFS_MAC_CONFIG_ONE     12'h200
`define OFS_BACK_TO_BACK_GAP   12'h220
`define OFS_STATION_ADDR_LOW   12'h300
`define OFS_ALIAS_CLEAR        2'h1
`define OFS_ALIAS_SET          2'h2
`define OFS_ALIAS_INVERT       2'h3

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define BIT_WHOLE_MAC_HOLD     15
`define BIT_BACKOFF_RESTART    14
`define BIT_RX_CTRL_HOLD       11
`define BIT_RX_FUNC_HOLD       10
`define BIT_TX_CTRL_HOLD       9
`define BIT_TX_FUNC_HOLD       8
`define BIT_LOOPBACK           4
`define BIT_SEND_FLOW_STOP     3
`define BIT_HONOR_FLOW_STOP    2
`define BIT_ACCEPT_EVERY       1
`define BIT_RECEIVE_ON         0

// ---------------------------------------------------------------
// Reset values and write masks
// ---------------------------------------------------------------
`define RST_MAC_CONFIG_ONE     16'h800d
`define MASK_MAC_CONFIG_ONE    16'hcf1f
`define RST_BACK_TO_BACK_GAP   7'h12
`define GAP_OFFSET_FULL        8'h03
`define GAP_OFFSET_HALF        8'h06
`define FACTORY_STATION_LOW    16'h0000

`endif

// ### design/gap_timer.v
// Inter-packet gap timer counting nibble-time enable pulses
`timescale 1ns/1ps
`include "mac_cfg_defs.vh"

module gap_timer (
    input  wire       mclk,
    input  wire       rst_b,
    input  wire       hold,
    input  wire       nibbleTick,
    input  wire       fullDuplex,
    input  wire [6:0] packetGapNibbles,
    input  wire       txFrameEnd,
    output reg        gapOpen
);
    reg  [7:0] count;
    wire [7:0] target;

    // Field holds gap minus offset, so add it back
    assign target = {1'b0, packetGapNibbles}
                  + (fullDuplex ? `GAP_OFFSET_FULL : `GAP_OFFSET_HALF);

    always @(posedge mclk) begin
        if (!rst_b || hold) begin
            count   <= 8'h00;
            gapOpen <= 1'b1;
        end else if (txFrameEnd) begin
            count   <= 8'h00;
            gapOpen <= 1'b0;
        end else if (!gapOpen && nibbleTick) begin
            if (count + 8'h01 >= target) begin
                gapOpen <= 1'b1;
            end
            count <= count + 8'h01;
        end
    end
endmodule // gap_timer

// ### design/backoff_lfsr.v
// Transmit backoff pseudo-random generator
`timescale 1ns/1ps

module backoff_lfsr #(
    parameter WIDTH = 10
) (
    input  wire             mclk,
    input  wire             rst_b,
    input  wire             restart,
    output reg  [WIDTH-1:0] value
);
    always @(posedge mclk) begin
        if (!rst_b || restart) begin
            value <= {{(WIDTH-1){1'b0}}, 1'b1};
        end else begin
            value <= {value[WIDTH-2:0], value[WIDTH-1] ^ value[WIDTH-4]};
        end
    end
endmodule // backoff_lfsr

// ### tb/phy_model.sv
// Far-side receive model: reports finished frames with FCS status and length
`timescale 1ns/1ps

module phy_model (
    input  wire       mclk,
    output reg        rxFrameDone,
    output reg        rxFcsBad,
    output reg  [2:0] rxBitLenLow
);
    reg busy;
    initial begin
        busy        = 1'b0;
        rxFrameDone = 1'b0;
        rxFcsBad    = 1'b0;
        rxBitLenLow = 3'h0;
    end
    // Status toggles between frames so a stale value is never trusted
    always @(negedge mclk) begin
        if (!busy) begin
            rxFcsBad    <= ~rxFcsBad;
            rxBitLenLow <= ~rxBitLenLow;
        end
    end
    task frame(input bad, input [2:0] len, input integer dly);
        begin
            repeat (dly) @(posedge mclk);
            if (dly > 0) #1;
            busy        = 1'b1;
            rxFcsBad    = bad;
            rxBitLenLow = len;
            rxFrameDone = 1'b1;
            @(posedge mclk);
            #1 rxFrameDone = 1'b0;
            busy        = 1'b0;
            @(posedge mclk);
            #1;
        end
    endtask
endmodule // phy_model

// ### tb/ethernet_mac_config_stats_sva.sv
// Port-level checker for the MAC configuration and statistics block
`timescale 1ns/1ps

module mac_cfg_stats_checker #(
    parameter NIBBLE_DIV = 10
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        busRead,
    input wire logic        busWrite,
    input wire logic [3:0]  busByteEn,
    input wire logic [31:0] busReadData,
    input wire logic        busReady,
    input wire logic        rxFromPhy,
    input wire logic        txFrameValid,
    input wire logic        txFrameEnd,
    input wire logic        rxAccept,
    input wire logic        rxSourceLoop,
    input wire logic        txGapOpen,
    input wire logic        macLogicHold,
    input wire logic        rxControlHold,
    input wire logic        rxFunctionHold,
    input wire logic        txControlHold,
    input wire logic        txFunctionHold,
    input wire logic [9:0]  backoffValue
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence accessReq;
        busRead || busWrite;
    endsequence
    sequence gapShut;
        !txGapOpen [*8];
    endsequence
    AST_READY_PULSE: assert property (accessReq |=> busReady)
        else $error("ready missing after access");
    AST_READY_IDLE: assert property (!(busRead || busWrite) |=> !busReady)
        else $error("ready without access");
    AST_UPPER_ZERO: assert property (busReady |-> busReadData[31:16] == 16'h0)
        else $error("upper read half not zero");
    AST_BYTE_READ_REFUSED: assert property (busRead && busByteEn != 4'h3
        && busByteEn != 4'hc && busByteEn != 4'hf |=> busReadData == 32'h0)
        else $error("narrow read returned data");
    AST_WHOLE_HOLD: assert property (macLogicHold |-> rxControlHold && rxFunctionHold
        && txControlHold && txFunctionHold)
        else $error("soft hold not covering sub-blocks");
    AST_RX_BLOCKED: assert property (rxAccept |-> !rxFunctionHold && !rxControlHold)
        else $error("frame accepted while receive held");
    AST_RX_SOURCE: assert property (rxAccept |->
        (rxSourceLoop ? $past(txFrameValid) : $past(rxFromPhy)))
        else $error("frame accepted from wrong source");
    AST_GAP_SHUT: assert property (txFrameEnd && !macLogicHold && !txFunctionHold
        |=> ##1 gapShut)
        else $error("gap opened too early");
    AST_BACKOFF_FROZEN: assert property (macLogicHold [*3] |-> $stable(backoffValue))
        else $error("backoff generator ran during hold");
endmodule // mac_cfg_stats_checker

bind ethernet_mac_config_stats mac_cfg_stats_checker #(.NIBBLE_DIV(NIBBLE_DIV)) u_chk (
    .mclk, .rst_b, .busRead, .busWrite, .busByteEn, .busReadData, .busReady, .rxFromPhy,
    .txFrameValid, .txFrameEnd, .rxAccept, .rxSourceLoop, .txGapOpen, .macLogicHold,
    .rxControlHold, .rxFunctionHold, .txControlHold, .txFunctionHold, .backoffValue);

// ### tb/ethernet_mac_config_stats_tb.sv
// Register-level testbench for the MAC configuration and statistics block
`timescale 1ns/1ps
`include "mac_cfg_defs.vh"

module ethernet_mac_config_stats_tb;
    localparam        ND  = 4;
    localparam [15:0] FST = 16'hc35a;
    localparam [11:0] CF  = `OFS_MAC_CONFIG_ONE;
    localparam [11:0] GP  = `OFS_BACK_TO_BACK_GAP;
    localparam [11:0] FC  = `OFS_FCS_ERROR_COUNT;
    localparam [11:0] ST  = `OFS_STATION_ADDR_LOW;
    reg         mclk, rst_b, busRead, busWrite, rxIsControl, rxFromPhy;
    reg         txFrameValid, txFrameEnd, fullDuplex, rxIsPause, txIsPause;
    reg  [11:0] busAddr;
    reg  [3:0]  busByteEn;
    reg  [31:0] busWriteData, rd;
    wire [31:0] busReadData;
    wire        busReady, rxFrameDone, rxFcsBad, rxAccept, pauseHonored, txPausePermit;
    wire        rxSourceLoop, txGapOpen, macLogicHold, rxControlHold, rxFunctionHold;
    wire        txControlHold, txFunctionHold;
    wire [2:0]  rxBitLenLow;
    wire [9:0]  backoffValue;
    wire [47:0] stationAddrLow;
    integer     err_total, compares, cyc, i, n;

    ethernet_mac_config_stats #(.FACTORY_STATION(FST), .NIBBLE_DIV(ND)) u_ethernet_mac_config_stats (
        .mclk, .rst_b, .busRead, .busWrite, .busAddr, .busByteEn, .busWriteData, .busReadData,
        .busReady, .rxFrameDone, .rxFcsBad, .rxBitLenLow, .rxIsControl, .rxIsPause, .rxFromPhy,
        .txFrameValid, .txIsPause, .txFrameEnd, .fullDuplex, .rxAccept, .pauseHonored,
        .txPausePermit, .rxSourceLoop, .txGapOpen, .macLogicHold, .rxControlHold,
        .rxFunctionHold, .txControlHold, .txFunctionHold, .backoffValue, .stationAddrLow);
    phy_model u_phy_model (.mclk, .rxFrameDone, .rxFcsBad, .rxBitLenLow);

    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("ERROR %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    // One access takes two cycles so strobes never re-assert in one step
    task acc(input w, input [11:0] a, input [3:0] be, input [31:0] d);
        begin
            busAddr = a; busByteEn = be; busWriteData = d; busWrite = w; busRead = !w;
            @(posedge mclk);
            #1 busWrite = 1'b0; busRead = 1'b0; rd = busReadData;
            check("ready", {31'h0, busReady}, 32'h1);
            @(posedge mclk);
            #1;
        end
    endtask
    task final_report;
        begin
            $display("compares %0d err_total %0d", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // Hang guard, well beyond the expected run length
    initial cyc = 0;
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 4000) begin
            err_total = err_total + 1;
            final_report;
        end
    end

    initial begin
        err_total = 0; compares = 0; rst_b = 1'b0; busRead = 1'b0; busWrite = 1'b0;
        busAddr = 12'h0; busByteEn = 4'h0; busWriteData = 32'h0; rxIsControl = 1'b0;
        rxFromPhy = 1'b1; txFrameValid = 1'b1; txFrameEnd = 1'b0; fullDuplex = 1'b1;
        rxIsPause = 1'b1; txIsPause = 1'b1;
        repeat (10) @(posedge mclk);
        #1 rst_b = 1'b1;
        check("soft hold", {31'h0, macLogicHold}, 32'h1);
        acc(0, CF, 4'hf, 0); check("config", rd, 32'h800d);
        acc(0, GP, 4'hf, 0); check("gap", rd, 32'h12);
        acc(0, ST, 4'hf, 0); check("station", rd, {16'h0, FST});
        acc(1, CF, 4'h3, 32'hd);
        check("soft hold", {31'h0, macLogicHold}, 32'h0);
        check("pause", {30'h0, txPausePermit, pauseHonored}, 32'h3);
        acc(1, CF + 12'h4, 4'hf, 32'hc);
        check("pause", {30'h0, txPausePermit, pauseHonored}, 32'h0);
        for (i = 0; i < 4; i = i + 1) begin
            acc(1, CF + 12'h8, 4'h3, 32'h100 << i);
            check("sub hold", {28'h0, txFunctionHold, txControlHold,
                rxFunctionHold, rxControlHold} << 0, 32'h8 >> i);
            acc(1, CF + 12'h4, 4'h3, 32'h100 << i);
        end
        check("accept", {31'h0, rxAccept}, 32'h1);
        txFrameValid = 1'b0;
        acc(1, CF + 12'h8, 4'h3, 32'h10);
        check("loop", {30'h0, rxSourceLoop, rxAccept}, 32'h2);
        txFrameValid = 1'b1;
        repeat (2) @(posedge mclk);
        #1 check("loop accept", {31'h0, rxAccept}, 32'h1);
        acc(1, CF + 12'hc, 4'h3, 32'h10);
        txFrameValid = 1'b0; rxIsControl = 1'b1;
        repeat (2) @(posedge mclk);
        #1 check("control drop", {30'h0, rxSourceLoop, rxAccept}, 32'h0);
        acc(1, CF + 12'h8, 4'h3, 32'h2);
        check("pass all", {31'h0, rxAccept}, 32'h1);
        acc(1, CF + 12'h4, 4'h3, 32'h1);
        check("rx off", {31'h0, rxAccept}, 32'h0);
        acc(0, CF, 4'hf, 0); check("config", rd, 32'h2);
        acc(1, GP, 4'h1, 32'h7f);
        acc(0, GP, 4'h3, 0); check("byte write", rd, 32'h12);
        u_phy_model.frame(1'b1, 3'h0, 0);
        u_phy_model.frame(1'b1, 3'h0, 2);
        u_phy_model.frame(1'b1, 3'h3, 0);
        u_phy_model.frame(1'b0, 3'h0, 1);
        acc(0, FC, 4'h1, 0); check("byte read", rd, 32'h0);
        acc(0, FC, 4'hc, 0);
        acc(0, FC, 4'h3, 0); check("fcs count", rd, 32'h2);
        acc(0, FC, 4'hf, 0); check("fcs clear", rd, 32'h0);
        acc(1, FC + 12'h8, 4'h3, 32'h5);
        fork
            acc(0, FC, 4'hf, 0);
            u_phy_model.frame(1'b1, 3'h0, 0);
        join
        check("fcs set", rd, 32'h5);
        acc(0, FC, 4'hf, 0); check("fcs keep", rd, 32'h1);
        for (i = 0; i < 2; i = i + 1) begin
            acc(1, GP, 4'h3, i ? 32'h12 : 32'h15);
            fullDuplex = (i == 0);
            txFrameEnd = 1'b1;
            @(posedge mclk);
            #1 txFrameEnd = 1'b0;
            // Gap output sits one register behind the timer
            @(posedge mclk);
            #1 n = 1;
            while (txGapOpen !== 1'b1 && n < 1000) begin
                @(posedge mclk);
                #1 n = n + 1;
            end
            check("gap time", {31'h0, n >= 24 * ND - 2 && n <= 25 * ND + 2}, 32'h1);
        end
        acc(1, ST, 4'hf, 32'h3412);
        check("octets", {16'h0, stationAddrLow[15:0]}, 32'h3412);
        acc(0, ST, 4'hf, 0); check("station", rd, 32'h3412);
        acc(1, CF + 12'h8, 4'h3, 32'hc000);
        repeat (6) @(posedge mclk);
        #1 check("soft hold", {31'h0, macLogicHold}, 32'h1);
        rd = {22'h0, backoffValue};
        repeat (3) @(posedge mclk);
        #1 check("backoff", {22'h0, backoffValue}, rd);
        final_report;
    end
endmodule // ethernet_mac_config_stats_tb
